// >>> verilog/pmwc_pkg.sv
package pmwc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   // Slow oscillator, nominal 32 kHz
   localparam int SLOW_OSC_PERIOD_NS = 31250;
   localparam int SLOW_DIV_CYCLES = SLOW_OSC_PERIOD_NS / CLK_PERIOD_NS;
   // Fast oscillator settling after restart
   localparam int OSC_START_NS = 200;
   localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Register offsets and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] POWER_CONTROL_OFFSET = 8'h87;
   localparam logic [7:0] CLOCK_SELECT_OFFSET = 8'h8f;
   localparam logic [7:0] POWER_STATUS_OFFSET = 8'h9e;
   localparam logic [7:0] WAKE_MASK_OFFSET = 8'h9f;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CLOCK_SELECT_RESET = 8'h0c;
   localparam logic [7:0] WAKE_MASK_RESET = 8'hff;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int PCTL_IDLE_BIT = 0;
   localparam int PCTL_STOP_BIT = 1;
   localparam int PCTL_SLEEP_BIT = 2;
   localparam int CSEL_SRC_LSB = 0;
   localparam int CSEL_RDY_LSB = 2;
   localparam int CSEL_DIV_LSB = 4;

   // Regulator-ready delays in slow-oscillator cycles
   localparam logic [8:0] READY_DELAY_0 = 9'h008;
   localparam logic [8:0] READY_DELAY_1 = 9'h010;
   localparam logic [8:0] READY_DELAY_2 = 9'h040;
   localparam logic [8:0] READY_DELAY_3 = 9'h100;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_FAST_DIV,
      SRC_SLOW,
      SRC_EXT
   } pmwc_src_t;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_IDLE,
      ST_STOP_FINAL,
      ST_STOP,
      ST_SLEEP,
      ST_REG_WAIT,
      ST_OSC_START
   } pmwc_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pmwc_bus_req_t;

   typedef struct packed {
      logic pulse;
      logic vector;
      logic [7:0] lines;
   } pmwc_wake_t;

   // ---------------------------------------------------------------
   // Decoders
   // ---------------------------------------------------------------
   function automatic logic [8:0] ready_delay(input logic [1:0] code);
      case (code)
         2'h0: ready_delay = READY_DELAY_0;
         2'h1: ready_delay = READY_DELAY_1;
         2'h2: ready_delay = READY_DELAY_2;
         default: ready_delay = READY_DELAY_3;
      endcase
   endfunction

   function automatic pmwc_src_t decode_src(input logic [1:0] code);
      case (code)
         2'h1: decode_src = SRC_SLOW;
         2'h3: decode_src = SRC_EXT;
         default: decode_src = SRC_FAST_DIV;
      endcase
   endfunction

endpackage

// >>> verilog/pmwc_ready_timer.sv
`timescale 1ns/1ns
module pmwc_ready_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [1:0] delay_code,
   output logic slow_tick,
   output logic done
);

   // ---------------------------------------------------------------
   // Slow oscillator tick, free running
   // ---------------------------------------------------------------
   localparam logic [8:0] DIV_LAST = 9'(pmwc_pkg::SLOW_DIV_CYCLES - 1);

   logic [8:0] div_q, div_d;
   logic tick_q, tick_d;
   logic [8:0] left_q, left_d;
   logic busy_q, busy_d;
   logic done_q, done_d;

   // Divider and delay count next values
   always_comb begin
      div_d = (div_q == DIV_LAST) ? 9'h000 : div_q + 9'h001;
      tick_d = (div_q == DIV_LAST);
      left_d = left_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (start) begin
         // Count starts fresh; a partial slow period may pass first
         left_d = pmwc_pkg::ready_delay(delay_code);
         busy_d = 1'b1;
      end else if (busy_q && tick_q) begin
         left_d = left_q - 9'h001;
         if (left_q == 9'h001) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q <= 9'h000;
         tick_q <= 1'b0;
         left_q <= 9'h000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
         left_q <= left_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign slow_tick = tick_q;
   assign done = done_q;

endmodule

// >>> verilog/pmwc_top.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01 - Eight-bit wake mask, one bit per interrupt line, all ones after reset.
// RULE_02 - Wake from STOP or SLEEP on a rising edge of an enabled line.
// RULE_03 - Wake ignores interrupt enables; disabled interrupt means no vectoring.
// RULE_04 - On wake, fast oscillator restarts before the system clock resumes.
// RULE_05 - STOP and SLEEP stop all clocks; only pins, bus and slow timer wake.
// RULE_06 - Idle bit stops the core clock; other peripherals keep running.
// RULE_07 - While idle, core and its integrated peripherals are unreachable.
// RULE_08 - Idle ends on reset or on an enabled interrupt line.
// RULE_09 - Leaving idle vectors at once to the waking interrupt.
// RULE_10 - Hardware clears the idle bit on return to normal operation.
// RULE_11 - Stop bit stops every clock and disables the fast oscillator.
// RULE_12 - Fast oscillator shuts down on its final clock edge entering STOP.
// RULE_13 - Wake or reset ends STOP; stop bit cleared, prior clock settings kept.
// RULE_14 - Interrupt ending STOP vectors at once to its routine.
// RULE_15 - Software picks the fast oscillator and stops other clocks before STOP.
// RULE_16 - SLEEP turns off main regulator; backup regulator and slow oscillator stay.
// RULE_17 - SLEEP exit re-enables regulator, waits ready delay, then resumes clock.
// RULE_18 - Clock source: divided fast, slow or external; divided fast by default.
// RULE_19 - Ready field codes 0..3 give 8, 16, 64, 256 slow cycles; default 256.
// RULE_20 - Source codes 00 and 10 fast divided, 01 slow, 11 external.
module pmwc_top (
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire pmwc_pkg::pmwc_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // Interrupt lines and clock-free wake sources
   input wire logic [7:0] ext_int,
   input wire logic [7:0] irq_enable,
   input wire logic bus_wake,
   input wire logic slow_timer_wake,
   input wire logic fast_osc_edge,
   // Clock, oscillator and regulator controls
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic fast_osc_en,
   output logic main_reg_en,
   output pmwc_pkg::pmwc_src_t clk_source,
   output logic [3:0] fast_osc_div,
   // Wake report towards the core
   output pmwc_pkg::pmwc_wake_t wake
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   // Sequencer and software-visible registers
   pmwc_pkg::pmwc_state_t state_q, state_d;
   logic [7:0] pctl_q, pctl_d;
   logic [7:0] csel_q, csel_d;
   logic [7:0] mask_q, mask_d;
   logic [7:0] rdata_q, rdata_d;

   // Last samples of the wake sources, captured wake lines and restart count
   logic [7:0] int_prev_q;
   logic bus_wake_prev_q;
   logic timer_wake_prev_q;
   logic [7:0] wake_lines_q, wake_lines_d;
   logic [1:0] osc_cnt_q, osc_cnt_d;

   // Output flops
   logic cpu_clk_en_q, cpu_clk_en_d;
   logic periph_clk_en_q, periph_clk_en_d;
   logic fast_osc_en_q, fast_osc_en_d;
   logic main_reg_en_q, main_reg_en_d;
   pmwc_pkg::pmwc_src_t src_q, src_d;
   pmwc_pkg::pmwc_wake_t wake_q, wake_d;

   // Decoded wake and bus terms
   logic [7:0] line_rise;
   logic [7:0] line_hit;
   logic side_hit;
   logic wake_hit;
   logic idle_exit;
   logic timer_start;
   logic timer_done;
   logic wr_pctl;

   // Last count of the oscillator restart wait
   localparam logic [1:0] OSC_LAST = 2'(pmwc_pkg::OSC_START_CYCLES - 1);

   // ---------------------------------------------------------------
   // Wake detection
   // ---------------------------------------------------------------
   // Edges only; a line held high from before entry cannot wake again
   assign line_rise = ext_int & ~int_prev_q; // RULE_02
   // Mask is independent of irq_enable on purpose
   assign line_hit = line_rise & mask_q; // RULE_01 RULE_03
   // Clock-free sources only; clocked peripherals are frozen anyway
   assign side_hit = (bus_wake & ~bus_wake_prev_q)
                   | (slow_timer_wake & ~timer_wake_prev_q); // RULE_05
   assign wake_hit = (|line_hit) | side_hit;
   // Idle ends on an enabled interrupt level, not the wake mask
   assign idle_exit = |(ext_int & irq_enable); // RULE_08
   // Mode requests arrive only through the power control register
   assign wr_pctl = bus_req.wr && (bus_req.addr == pmwc_pkg::POWER_CONTROL_OFFSET);

   // ---------------------------------------------------------------
   // Regulator-ready delay on the slow oscillator
   // ---------------------------------------------------------------
   // Slow tick stays internal; only the done pulse is used
   pmwc_ready_timer u_ready (
      .clk(clk),
      .rst(rst),
      .start(timer_start),
      .delay_code(csel_q[pmwc_pkg::CSEL_RDY_LSB +: 2]),
      .slow_tick(),
      .done(timer_done)
   );

   // ---------------------------------------------------------------
   // Power state sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      pctl_d = pctl_q;
      wake_lines_d = wake_lines_q;
      osc_cnt_d = osc_cnt_q;
      timer_start = 1'b0;
      wake_d = '0;
      case (state_q)
         // Normal operation until software asks for a mode
         pmwc_pkg::ST_RUN: begin
            if (wr_pctl) begin
               pctl_d = bus_req.wdata;
               // Deepest requested mode wins
               if (bus_req.wdata[pmwc_pkg::PCTL_SLEEP_BIT]) begin
                  state_d = pmwc_pkg::ST_SLEEP; // RULE_16
               end else if (bus_req.wdata[pmwc_pkg::PCTL_STOP_BIT]) begin
                  state_d = pmwc_pkg::ST_STOP_FINAL; // RULE_11
               end else if (bus_req.wdata[pmwc_pkg::PCTL_IDLE_BIT]) begin
                  state_d = pmwc_pkg::ST_IDLE; // RULE_06
               end
            end
         end

         // Core halted, other peripherals running
         pmwc_pkg::ST_IDLE: begin
            if (idle_exit) begin
               state_d = pmwc_pkg::ST_RUN;
               pctl_d[pmwc_pkg::PCTL_IDLE_BIT] = 1'b0; // RULE_10
               wake_d.pulse = 1'b1;
               wake_d.vector = 1'b1; // RULE_09
               wake_d.lines = ext_int & irq_enable;
            end
         end

         pmwc_pkg::ST_STOP_FINAL: begin
            // Wait for the oscillator's last edge before gating it
            if (wake_hit) begin
               wake_lines_d = line_hit;
               osc_cnt_d = 2'h0;
               state_d = pmwc_pkg::ST_OSC_START;
            end else if (fast_osc_edge) begin
               state_d = pmwc_pkg::ST_STOP; // RULE_12
            end
         end

         // All clocks frozen; only clock-free sources can wake
         pmwc_pkg::ST_STOP: begin
            if (wake_hit) begin
               wake_lines_d = line_hit;
               osc_cnt_d = 2'h0;
               state_d = pmwc_pkg::ST_OSC_START; // RULE_04
            end
         end

         // Backup regulator and slow oscillator only
         pmwc_pkg::ST_SLEEP: begin
            if (wake_hit) begin
               wake_lines_d = line_hit;
               timer_start = 1'b1;
               state_d = pmwc_pkg::ST_REG_WAIT; // RULE_17
            end
         end

         pmwc_pkg::ST_REG_WAIT: begin
            // Clock stays off until the regulator has settled
            if (timer_done) begin
               osc_cnt_d = 2'h0;
               state_d = pmwc_pkg::ST_OSC_START; // RULE_17
            end
         end

         // Restarted oscillator settles before the clocks return
         pmwc_pkg::ST_OSC_START: begin
            osc_cnt_d = osc_cnt_q + 2'h1;
            if (osc_cnt_q == OSC_LAST) begin
               state_d = pmwc_pkg::ST_RUN; // RULE_04
               // Clock select is untouched, so old settings resume
               pctl_d[pmwc_pkg::PCTL_STOP_BIT] = 1'b0; // RULE_13
               pctl_d[pmwc_pkg::PCTL_SLEEP_BIT] = 1'b0;
               wake_d.pulse = 1'b1;
               // No vector for a disabled line: CPU runs on
               wake_d.vector = |(wake_lines_q & irq_enable); // RULE_03 RULE_14
               wake_d.lines = wake_lines_q;
            end
         end

         // Unused state codes fall back to RUN
         default: begin
            state_d = pmwc_pkg::ST_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Clock, oscillator and regulator enables
   // ---------------------------------------------------------------
   always_comb begin
      // Core and integrated peripherals only run in RUN
      cpu_clk_en_d = (state_d == pmwc_pkg::ST_RUN); // RULE_06 RULE_07
      // Other peripherals keep their clock through IDLE
      periph_clk_en_d = (state_d == pmwc_pkg::ST_RUN)
                      || (state_d == pmwc_pkg::ST_IDLE); // RULE_05 RULE_11
      // Cut for STOP only once STOP proper is reached, never mid-pulse; SLEEP cuts it at once
      fast_osc_en_d = !((state_d == pmwc_pkg::ST_STOP)
                     || (state_d == pmwc_pkg::ST_SLEEP)
                     || (state_d == pmwc_pkg::ST_REG_WAIT)); // RULE_11 RULE_12
      // Backup regulator holds state; main one is off only in SLEEP
      main_reg_en_d = (state_d != pmwc_pkg::ST_SLEEP); // RULE_16
      // Code 10 acts as 00, so only three sources exist
      src_d = pmwc_pkg::decode_src(csel_q[pmwc_pkg::CSEL_SRC_LSB +: 2]); // RULE_18 RULE_20
   end

   // ---------------------------------------------------------------
   // Register writes and read data
   // ---------------------------------------------------------------
   always_comb begin
      csel_d = csel_q;
      mask_d = mask_q;
      rdata_d = 8'h00;
      // Writes to unmapped offsets are dropped
      if (bus_req.wr) begin
         case (bus_req.addr)
            pmwc_pkg::CLOCK_SELECT_OFFSET: csel_d = bus_req.wdata; // RULE_19
            pmwc_pkg::WAKE_MASK_OFFSET: mask_d = bus_req.wdata; // RULE_01
            default: begin
               csel_d = csel_q;
            end
         endcase
      end

      // Read data is zero outside the cycle after a read
      if (bus_req.rd) begin
         case (bus_req.addr)
            pmwc_pkg::POWER_CONTROL_OFFSET: rdata_d = pctl_q;
            pmwc_pkg::CLOCK_SELECT_OFFSET: rdata_d = csel_q;
            pmwc_pkg::WAKE_MASK_OFFSET: rdata_d = mask_q;
            pmwc_pkg::POWER_STATUS_OFFSET: begin
               rdata_d = {4'h0, wake_q.vector, cpu_clk_en_q, main_reg_en_q,
                          fast_osc_en_q};
            end
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   // Reset also ends IDLE, STOP and SLEEP outright
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Sequencer and registers
         state_q <= pmwc_pkg::ST_RUN; // RULE_08 RULE_13
         pctl_q <= pmwc_pkg::POWER_CONTROL_RESET;
         csel_q <= pmwc_pkg::CLOCK_SELECT_RESET; // RULE_18 RULE_19
         mask_q <= pmwc_pkg::WAKE_MASK_RESET; // RULE_01
         rdata_q <= 8'h00;
         // Edge history idles low like the pins
         int_prev_q <= 8'h00;
         bus_wake_prev_q <= 1'b0;
         timer_wake_prev_q <= 1'b0;
         wake_lines_q <= 8'h00;
         osc_cnt_q <= 2'h0;
         // Everything runs out of reset
         cpu_clk_en_q <= 1'b1;
         periph_clk_en_q <= 1'b1;
         fast_osc_en_q <= 1'b1;
         main_reg_en_q <= 1'b1;
         src_q <= pmwc_pkg::SRC_FAST_DIV;
         wake_q <= '0;
      end else begin
         // Sequencer and registers
         state_q <= state_d;
         pctl_q <= pctl_d;
         csel_q <= csel_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
         // Last samples for edge detection, captured wake lines and restart count
         int_prev_q <= ext_int;
         bus_wake_prev_q <= bus_wake;
         timer_wake_prev_q <= slow_timer_wake;
         wake_lines_q <= wake_lines_d;
         osc_cnt_q <= osc_cnt_d;
         // Output flops
         cpu_clk_en_q <= cpu_clk_en_d;
         periph_clk_en_q <= periph_clk_en_d;
         fast_osc_en_q <= fast_osc_en_d;
         main_reg_en_q <= main_reg_en_d;
         src_q <= src_d;
         wake_q <= wake_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ---------------------------------------------------------------
   assign bus_rdata = rdata_q;
   assign cpu_clk_en = cpu_clk_en_q;
   assign periph_clk_en = periph_clk_en_q;
   assign fast_osc_en = fast_osc_en_q;
   assign main_reg_en = main_reg_en_q;
   assign clk_source = src_q;
   assign fast_osc_div = csel_q[pmwc_pkg::CSEL_DIV_LSB +: 4];
   assign wake = wake_q;

endmodule

// >>> dv/pmwc_props.sv
`timescale 1ns/1ns
module pmwc_props (
   input wire logic clk,
   input wire logic rst,
   input wire pmwc_pkg::pmwc_bus_req_t bus_req,
   input wire logic [7:0] ext_int,
   input wire logic [7:0] irq_enable,
   input wire logic bus_wake,
   input wire logic slow_timer_wake,
   input wire logic fast_osc_edge,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic fast_osc_en,
   input wire logic main_reg_en,
   input wire pmwc_pkg::pmwc_wake_t wake
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------------
   logic slept_q;
   logic [15:0] wait_q;
   logic run;
   logic pwr_wr;
   logic stop_st;

   // Mode decode from the enables alone; reg wait looks like STOP otherwise
   assign run = cpu_clk_en & periph_clk_en & fast_osc_en & main_reg_en;
   assign pwr_wr = bus_req.wr && bus_req.addr == pmwc_pkg::POWER_CONTROL_OFFSET && run;
   assign stop_st = !periph_clk_en && !fast_osc_en && main_reg_en && !slept_q;

   // Remembers a SLEEP until clocks return; counts regulator-on cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slept_q <= 1'b0;
         wait_q <= 16'h0000;
      end else begin
         slept_q <= !main_reg_en || (slept_q && !periph_clk_en);
         wait_q <= main_reg_en ? wait_q + 16'h0001 : 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   sequence s_restart;
      fast_osc_en ##2 (periph_clk_en && wake.pulse && !wake.vector);
   endsequence
   sequence s_back;
      run ##1 !wake.pulse;
   endsequence

   property p_idle_in;
      pwr_wr && bus_req.wdata[2:0] == 3'h1 |=> !cpu_clk_en && periph_clk_en;
   endproperty
   a_idle_in: assert property (p_idle_in) else $error("idle entry wrong");
   property p_stop_in;
      pwr_wr && bus_req.wdata[2:1] == 2'h1 |=> !cpu_clk_en && !periph_clk_en && fast_osc_en;
   endproperty
   a_stop_in: assert property (p_stop_in) else $error("stop entry wrong");
   property p_sleep_in;
      pwr_wr && bus_req.wdata[2] |=> !main_reg_en && !fast_osc_en && !periph_clk_en;
   endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("sleep entry wrong");
   property p_idle_out;
      !cpu_clk_en && periph_clk_en && |(ext_int & irq_enable)
         |=> cpu_clk_en && wake.pulse && wake.vector;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("idle exit wrong");
   property p_osc_final;
      $fell(fast_osc_en) && main_reg_en |-> $past(fast_osc_edge);
   endproperty
   a_osc_final: assert property (p_osc_final) else $error("osc cut early");
   property p_osc_first;
      $rose(periph_clk_en) |-> $past(fast_osc_en, 2);
   endproperty
   a_osc_first: assert property (p_osc_first) else $error("clock before osc");
   property p_stop_wake;
      stop_st && $rose(bus_wake) |=> s_restart;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop wake wrong");
   property p_sleep_wake;
      !main_reg_en && $past(main_reg_en) == 1'b0 && $rose(slow_timer_wake)
         |=> main_reg_en && !fast_osc_en;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake wrong");
   property p_reg_delay;
      slept_q && $rose(fast_osc_en) |-> wait_q >= 7 * pmwc_pkg::SLOW_DIV_CYCLES;
   endproperty
   a_reg_delay: assert property (p_reg_delay) else $error("ready delay short");
   property p_pulse;
      wake.pulse |-> s_back;
   endproperty
   a_pulse: assert property (p_pulse) else $error("wake pulse wrong");
endmodule

bind pmwc_top pmwc_props u_pmwc_props (.clk, .rst, .bus_req, .ext_int, .irq_enable,
   .bus_wake, .slow_timer_wake, .fast_osc_edge, .cpu_clk_en, .periph_clk_en,
   .fast_osc_en, .main_reg_en, .wake);

// >>> dv/pmwc_far_end.sv
`timescale 1ns/1ns
module pmwc_far_end (
   input wire logic clk,
   input wire logic rst,
   input wire logic periph_clk_en,
   input wire logic fast_osc_en,
   input wire logic main_reg_en,
   input wire logic [9:0] src_req,
   output logic [7:0] ext_int,
   output logic bus_wake,
   output logic slow_timer_wake,
   output logic fast_osc_edge
);
   logic [2:0] lag_q;

   // Unclocked wake sources; oscillator marks its last edge a few cycles late
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {slow_timer_wake, bus_wake, ext_int} <= 10'h000;
         lag_q <= 3'h0;
         fast_osc_edge <= 1'b0;
      end else begin
         {slow_timer_wake, bus_wake, ext_int} <= src_req;
         lag_q <= (!periph_clk_en && fast_osc_en && main_reg_en) ? lag_q + 3'h1 : 3'h0;
         fast_osc_edge <= lag_q == 3'h3;
      end
   end
endmodule

// >>> dv/power_mode_wakeup_control_bench.sv
`timescale 1ns/1ns
module power_mode_wakeup_control_bench;
   logic clk;
   logic rst;
   pmwc_pkg::pmwc_bus_req_t bus_req;
   logic [7:0] bus_rdata;
   logic [7:0] irq_enable;
   logic [9:0] src_req;
   logic [7:0] ext_int;
   logic bus_wake;
   logic slow_timer_wake;
   logic fast_osc_edge;
   logic cpu_clk_en;
   logic periph_clk_en;
   logic fast_osc_en;
   logic main_reg_en;
   pmwc_pkg::pmwc_src_t clk_source;
   logic [3:0] fast_osc_div;
   pmwc_pkg::pmwc_wake_t wake;
   int failures = 0;
   int cmp_count = 0;
   int waited;
   int lo;
   logic [31:0] seed = 32'hb990;

   pmwc_top u_pmwc_top (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .ext_int(ext_int), .irq_enable(irq_enable), .bus_wake(bus_wake),
      .slow_timer_wake(slow_timer_wake), .fast_osc_edge(fast_osc_edge),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .fast_osc_en(fast_osc_en),
      .main_reg_en(main_reg_en), .clk_source(clk_source), .fast_osc_div(fast_osc_div),
      .wake(wake));
   pmwc_far_end u_pmwc_far_end (.clk(clk), .rst(rst), .periph_clk_en(periph_clk_en),
      .fast_osc_en(fast_osc_en), .main_reg_en(main_reg_en), .src_req(src_req),
      .ext_int(ext_int), .bus_wake(bus_wake), .slow_timer_wake(slow_timer_wake),
      .fast_osc_edge(fast_osc_edge));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [1:0] exp_src(input logic [1:0] c);
      return (c == 2'h1) ? 2'h1 : (c == 2'h3) ? 2'h2 : 2'h0;
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bus tasks enter and leave just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req <= '0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      @(negedge clk);
      chk("rdata", bus_rdata, exp);
      @(posedge clk);
   endtask
   // Leaves at the falling edge where the wake pulse is seen
   task automatic wait_wake;
      waited = 0;
      @(negedge clk);
      while (wake.pulse !== 1'b1 && waited < 30000) begin
         @(negedge clk);
         waited++;
      end
      chk("woke", wake.pulse, 1'b1);
   endtask
   task automatic test_done;
      $display("Comparisons %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Whole run needs roughly 7500 cycles
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      test_done;
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      bus_req = '0;
      irq_enable = 8'h00;
      src_req = 10'h000;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk(8'h9f, 8'hff);
      rchk(8'h8f, 8'h0c);
      rchk(8'h10, 8'h00);
      rchk(8'h9e, 8'h07);
      chk("src", clk_source, 2'h0);
      // Every source code with a random divider
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(8'h8f, {seed[7:4], 2'h3, 2'(i)});
         @(negedge clk);
         chk("src", clk_source, exp_src(2'(i)));
         chk("div", fast_osc_div, seed[7:4]);
         @(posedge clk);
      end
      seed = lfsr(seed);
      wr(8'h9f, seed[15:8]);
      rchk(8'h9f, seed[15:8]);
      // Idle left on an enabled level
      irq_enable <= 8'h20;
      wr(8'h87, 8'h01);
      @(negedge clk);
      chk("idle", {cpu_clk_en, periph_clk_en}, 2'h1);
      @(posedge clk);
      src_req <= 10'h020;
      wait_wake;
      chk("ivec", wake.vector, 1'b1);
      chk("ilines", wake.lines, 8'h20);
      @(posedge clk);
      src_req <= 10'h000;
      rchk(8'h87, 8'h00);
      // Stop: line wake with irq off, with irq on, then bus wake
      for (int v = 0; v < 3; v++) begin
         wr(8'h8f, 8'h0c);
         wr(8'h9f, 8'h02);
         irq_enable <= v ? 8'h02 : 8'h00;
         src_req <= 10'h002;
         repeat (3) @(posedge clk);
         wr(8'h87, 8'h02);
         src_req <= 10'h006;
         repeat (20) @(posedge clk);
         @(negedge clk);
         chk("stopped", fast_osc_en, 1'b0);
         @(posedge clk);
         src_req <= 10'h004;
         repeat (2) @(posedge clk);
         src_req <= (v == 2) ? 10'h104 : 10'h006;
         wait_wake;
         chk("svec", wake.vector, v == 1);
         chk("slines", wake.lines, (v == 2) ? 8'h00 : 8'h02);
         @(posedge clk);
         src_req <= 10'h000;
         rchk(8'h87, 8'h00);
         chk("kept", clk_source, 2'h0);
      end
      // Sleep with ready codes 0 and 1, timer then bus wake
      for (int c = 0; c < 2; c++) begin
         wr(8'h8f, c ? 8'h04 : 8'h00);
         wr(8'h87, 8'h04);
         repeat (5) @(posedge clk);
         src_req <= c ? 10'h100 : 10'h200;
         wait_wake;
         lo = (c ? 15 : 7) * pmwc_pkg::SLOW_DIV_CYCLES;
         chk("delay", waited >= lo && waited <= lo + pmwc_pkg::SLOW_DIV_CYCLES + 8, 1'b1);
         chk("slept", {main_reg_en, fast_osc_en, cpu_clk_en}, 3'h7);
         @(posedge clk);
         src_req <= 10'h000;
      end
      test_done;
   end
endmodule
